// ### design/qdc_sync.sv
`timescale 1ns/1ps
module qdc_sync
  import qdc_pkg::*;
#(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          meta_q[gi]   <= 1'b0;
          sync_out[gi] <= 1'b0;
        end else if (ce_in) begin
          meta_q[gi]   <= async_in[gi];
          sync_out[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

endmodule : qdc_sync

// ### design/qdc_top.sv
`timescale 1ns/1ps
module qdc_top
  import qdc_pkg::*;
#(
  parameter int unsigned MARK_POS  = FRM_MARK_POS,
  parameter logic        MARK_CTRL = FRM_MARK_CTRL
) (
  // clock, reset, enable
  input  wire logic        sys_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        clk_en_in,
  // serial link pins and the hard power-on pin
  input  wire logic        ser_clk_in,
  input  wire logic        ser_data_in,
  input  wire logic        ser_en_in,
  input  wire logic        hard_power_on_pin_in,
  // channel outputs
  output logic [7:0]       channel_a_output_out,
  output logic [7:0]       channel_b_output_out,
  output logic [7:0]       channel_c_output_out,
  output logic [7:0]       channel_d_output_out,
  output logic [3:0]       gain_select_out,
  output logic [3:0]       chan_active_out,
  output logic             single_buf_out
);

  ////////////////////////////////////////////////////////////////////////
  logic [1:0]  rst_sync_q;
  logic        rst_n;
  logic [3:0]  pins_s;
  logic        sclk_s;
  logic        sdat_s;
  logic        sen_s;
  logic        hard_power_on_pin_s;
  logic        sclk_prev_q;
  logic        sen_prev_q;
  logic        sclk_fall;
  logic        sen_fall;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // the pin is sampled like the others; its effect needs no serial edge
  qdc_sync #(.WIDTH(4)) u_sync (
    .clk_in   (sys_clk_in),
    .rst_n_in (rst_n),
    .ce_in    (clk_en_in),
    .async_in ({hard_power_on_pin_in, ser_en_in, ser_data_in, ser_clk_in}),
    .sync_out (pins_s)
  );
  assign {hard_power_on_pin_s, sen_s, sdat_s, sclk_s} = pins_s;

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_q <= 1'b0;
      sen_prev_q  <= 1'b0;
    end else if (clk_en_in) begin
      sclk_prev_q <= sclk_s;
      sen_prev_q  <= sen_s;
    end
  end
  assign sclk_fall = sclk_prev_q & ~sclk_s & sen_s;
  assign sen_fall  = sen_prev_q & ~sen_s;

  ////////////////////////////////////////////////////////////////////////
  // shifter
  qdc_state_e  state_q;
  logic [11:0] shift_q;
  logic [3:0]  bitcnt_q;
  logic [11:0] word_d;
  logic        word_done;

  assign word_d    = {shift_q[10:0], sdat_s};
  assign word_done = sclk_fall && (bitcnt_q == 4'(WORD_BITS - 1));

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= QDC_IDLE;
      shift_q  <= 12'h000;
      bitcnt_q <= RST_BITCNT;
    end else if (clk_en_in) begin
      case (state_q)
        QDC_IDLE: begin
          if (sen_s) begin
            state_q  <= QDC_SHIFT;
            bitcnt_q <= RST_BITCNT;
          end
        end
        QDC_SHIFT: begin
          if (!sen_s) begin
            state_q <= QDC_IDLE;
          end else if (sclk_fall) begin
            shift_q  <= word_d;
            bitcnt_q <= word_done ? RST_BITCNT : bitcnt_q + 4'h1;
          end
        end
        QDC_WAIT: state_q <= QDC_IDLE;
        default:  state_q <= QDC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control word and channel registers
  qdc_ctrl_s   ctrl_q;
  logic [7:0]  buf_q  [NUM_CHAN];
  logic        cwrite;
  logic        is_ctrl;
  logic [1:0]  waddr;
  logic        dwrite;

  assign is_ctrl = word_d[MARK_POS] == MARK_CTRL;
  assign waddr   = {word_d[FRM_ADDR_HI], word_d[FRM_ADDR_LO]};
  assign cwrite  = word_done && state_q == QDC_SHIFT && is_ctrl;
  assign dwrite  = word_done && state_q == QDC_SHIFT && !is_ctrl;

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= '{single_buf: RST_MODE, gain: RST_GAIN,
                  keep_on: RST_KEEP, soft_act: RST_ACT};
    end else if (clk_en_in && cwrite) begin
      ctrl_q.single_buf <= ctrl_q.single_buf | word_d[CTL_MODE_POS];
      ctrl_q.gain       <= word_d[CTL_GAIN_LSB +: 4];
      ctrl_q.keep_on    <= word_d[CTL_KEEP_LSB +: 4];
      ctrl_q.soft_act   <= word_d[CTL_ACT_POS];
    end
  end

  // input buffers written per channel; outputs follow per mode
  logic [7:0] out_q [NUM_CHAN];
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          buf_q[ch] <= RST_CODE;
        end else if (clk_en_in && dwrite && waddr == 2'(ch)) begin
          // gain comes from the control word alone, the data gain bit is
          // not kept
          buf_q[ch] <= word_d[FRM_CODE_LSB +: 8];
        end
      end
      always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          out_q[ch] <= RST_CODE;
        end else if (clk_en_in) begin
          if (ctrl_q.single_buf && dwrite && waddr == 2'(ch)) begin
            out_q[ch] <= word_d[FRM_CODE_LSB +: 8];
          end else if (!ctrl_q.single_buf && sen_fall) begin
            out_q[ch] <= buf_q[ch];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // outputs
  logic [3:0] active_d;
  assign active_d = ctrl_q.keep_on |
                    {4{ctrl_q.soft_act & hard_power_on_pin_s}};

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      chan_active_out <= 4'h0;
      gain_select_out <= RST_GAIN;
      single_buf_out  <= RST_MODE;
      channel_a_output_out <= RST_CODE;
      channel_b_output_out <= RST_CODE;
      channel_c_output_out <= RST_CODE;
      channel_d_output_out <= RST_CODE;
    end else if (clk_en_in) begin
      chan_active_out <= active_d;
      gain_select_out <= ctrl_q.gain;
      single_buf_out  <= ctrl_q.single_buf;
      channel_a_output_out <= out_q[0];
      channel_b_output_out <= out_q[1];
      channel_c_output_out <= out_q[2];
      channel_d_output_out <= out_q[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n);

  sequence s_ctrl_done;
    clk_en_in && word_done && state_q == QDC_SHIFT && is_ctrl;
  endsequence

  mode_sticky_a: assert property (
    ctrl_q.single_buf |=> ctrl_q.single_buf)
    else $error("single-buffer mode cleared");
  keep_on_a: assert property (
    clk_en_in && ctrl_q.keep_on[0] |=> chan_active_out[0])
    else $error("kept-on channel not active");
  shut_a: assert property (
    clk_en_in && !ctrl_q.keep_on[1] && !ctrl_q.soft_act |=>
      !chan_active_out[1])
    else $error("channel active without activate");
  pin_act_a: assert property (
    clk_en_in && ctrl_q.soft_act && hard_power_on_pin_s |=> chan_active_out == 4'hF)
    else $error("pin did not activate channels");
  ctrl_load_a: assert property (
    s_ctrl_done ##1 1'b1 |-> ctrl_q.soft_act == $past(word_d[CTL_ACT_POS]))
    else $error("control word not loaded");
  gain_out_a: assert property (
    clk_en_in |=> gain_select_out == $past(ctrl_q.gain))
    else $error("gain output mismatch");
  dbl_hold_a: assert property (
    clk_en_in && !ctrl_q.single_buf && !sen_fall |=> $stable(out_q[2]))
    else $error("double-buffered output moved early");
  dbl_upd_a: assert property (
    clk_en_in && !ctrl_q.single_buf && sen_fall |=>
      out_q[3] == $past(buf_q[3]))
    else $error("outputs not updated on enable fall");
  single_upd_a: assert property (
    clk_en_in && ctrl_q.single_buf && dwrite && waddr == 2'h1 |=>
      out_q[1] == $past(word_d[7:0]))
    else $error("single-buffered word not applied");
  no_shift_a: assert property (
    clk_en_in && !sen_s |=> $stable(shift_q))
    else $error("shift while enable low");

endmodule : qdc_top

// ### dv/qdc_ser_host.sv
`timescale 1ns/1ps
module qdc_ser_host (
  // pacing clock
  input  wire logic sys_clk_in,
  // serial pins
  output logic      ser_clk_out,
  output logic      ser_data_out,
  output logic      ser_en_out
);
  initial begin
    ser_clk_out  = 1'b0;
    ser_data_out = 1'b0;
    ser_en_out   = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask : wait_n
  // clock idles low between frames; half period is 4 system clocks
  task automatic send_word(input logic [11:0] w);
    for (int i = 11; i >= 0; i--) begin
      ser_data_out = w[i];
      ser_clk_out  = 1'b1;
      wait_n(4);
      ser_clk_out  = 1'b0;
      wait_n(4);
    end
    // hold time over: no stale bit left on the line; one cycle passes so
    // a following word never drives the data line twice in one step
    ser_data_out = ~w[0];
    wait_n(1);
  endtask : send_word
  task automatic frame_open();
    ser_en_out = 1'b1;
    wait_n(4);
  endtask : frame_open
  task automatic frame_close();
    ser_en_out = 1'b0;
    wait_n(4);
  endtask : frame_close
  // clock pulses with enable low must load nothing
  task automatic noise();
    for (int i = 0; i < 12; i++) begin
      ser_data_out = ~ser_data_out;
      ser_clk_out  = ~ser_clk_out;
      wait_n(4);
    end
  endtask : noise
endmodule : qdc_ser_host

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import qdc_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        resetn_in  = 1'b0;
  logic        pin        = 1'b0;
  logic        ce         = 1'b1;
  logic        sclk, sdat, sen, single_o;
  logic [7:0]  ca, cb, cc, cd;
  logic [3:0]  gain_o, act_o, m_gain, m_keep;
  logic        m_act, m_single;
  logic [7:0]  m_buf[4];
  logic [7:0]  m_out[4];
  logic [40:0] exp_q[$];
  logic [40:0] last_exp, prev;
  int          failures  = 0;
  int          tests_run = 0;
  int          seed      = 74712;
  wire  [40:0] snap = {ca, cb, cc, cd, gain_o, act_o, single_o};

  always #25 sys_clk_in = ~sys_clk_in;

  qdc_top uut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .clk_en_in(ce), .ser_clk_in(sclk), .ser_data_in(sdat),
    .ser_en_in(sen), .hard_power_on_pin_in(pin),
    .channel_a_output_out(ca), .channel_b_output_out(cb),
    .channel_c_output_out(cc), .channel_d_output_out(cd),
    .gain_select_out(gain_o), .chan_active_out(act_o),
    .single_buf_out(single_o));
  qdc_ser_host host (.sys_clk_in(sys_clk_in), .ser_clk_out(sclk),
    .ser_data_out(sdat), .ser_en_out(sen));

  ////////////////////////////////////////////////////////////////////
  function automatic logic [40:0] model();
    logic [3:0] act;
    act = m_keep | {4{m_act & pin}};
    return {m_out[0], m_out[1], m_out[2], m_out[3], m_gain, act, m_single};
  endfunction : model
  // expectations are queued before the stimulus that causes them
  task automatic note();
    if (model() !== last_exp) begin
      last_exp = model();
      exp_q.push_back(last_exp);
    end
  endtask : note
  task automatic chk(input logic [40:0] got, input logic [40:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic put_ctrl(input logic md, input logic [3:0] g, k,
                          input logic a);
    m_single = m_single | md;
    m_gain = g;
    m_keep = k;
    m_act  = a;
    note();
    host.send_word({FRM_MARK_CTRL, 1'b0, md, g, k, a});
  endtask : put_ctrl
  task automatic put_data(input logic [1:0] ad);
    logic [7:0] c;
    c = 8'($random(seed));
    m_buf[ad] = c;
    if (m_single) m_out[ad] = c;
    note();
    host.send_word({~FRM_MARK_CTRL, ad, 1'b0, c});
  endtask : put_data
  task automatic end_frame();
    if (!m_single) m_out = m_buf;
    note();
    host.frame_close();
    host.wait_n(12);
  endtask : end_frame
  // power-on contents of the control word and of every channel
  task automatic model_reset();
    m_gain   = 4'hF;
    m_keep   = 4'h0;
    m_act    = 1'b0;
    m_single = 1'b0;
    for (int i = 0; i < 4; i++) m_buf[i] = 8'h00;
    m_out = m_buf;
  endtask : model_reset
  task automatic finish_test();
    if (exp_q.size() != 0) failures++;
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////
  always @(negedge sys_clk_in) begin
    if (resetn_in && snap !== prev) begin
      if (exp_q.size() == 0) chk(snap, last_exp);
      else chk(snap, exp_q.pop_front());
      prev = snap;
    end
  end

  initial begin
    #3000000;
    failures++;
    finish_test();
  end

  initial begin
    model_reset();
    last_exp = model();
    prev = last_exp;
    host.wait_n(8);
    resetn_in = 1'b1;
    host.wait_n(5);
    chk(snap, model());
    host.noise();
    host.frame_open();
    for (int i = 0; i < 4; i++) put_data(2'(i));
    put_data(2'h1);
    end_frame();
    for (int i = 0; i < 8; i++) begin
      pin = i[0];
      note();
      host.wait_n(12);
      host.frame_open();
      put_ctrl(1'b0, 4'($random(seed)), 4'($random(seed)), i[1]);
      end_frame();
      pin = ~pin;
      note();
      host.wait_n(12);
    end
    host.frame_open();
    put_ctrl(1'b1, 4'hA, 4'h0, 1'b1);
    put_data(2'h1);
    put_ctrl(1'b0, 4'h5, 4'h3, 1'b1);
    put_data(2'h3);
    end_frame();
    // a pin change while the clock enable is low must not show until it
    // rises again; any earlier move is compared against the old state
    ce = 1'b0;
    pin = 1'b1;
    host.wait_n(12);
    ce = 1'b1;
    note();
    host.wait_n(12);
    // a second power-on reset is the only way back to double buffering
    resetn_in = 1'b0;
    host.wait_n(8);
    model_reset();
    note();
    resetn_in = 1'b1;
    host.wait_n(5);
    host.frame_open();
    put_data(2'h0);
    end_frame();
    finish_test();
  end
endmodule : tb_top

// ### pkg/qdc_pkg.sv
package qdc_pkg;

  localparam int unsigned NUM_CHAN       = 4;
  localparam int unsigned CODE_W         = 8;
  localparam int unsigned ADDR_W         = 2;
  localparam int unsigned WORD_BITS      = 12;
  localparam int unsigned CTRL_BITS      = 10;

  // frame layout (first bit shifted in lands in the msb)
  localparam int unsigned FRM_MARK_POS   = 11;
  localparam int unsigned FRM_ADDR_HI    = 10;
  localparam int unsigned FRM_ADDR_LO    = 9;
  localparam int unsigned FRM_GAIN_POS   = 8;
  localparam int unsigned FRM_CODE_LSB   = 0;
  localparam logic        FRM_MARK_CTRL  = 1'h1;

  // control word field positions
  localparam int unsigned CTL_MODE_POS   = 9;
  localparam int unsigned CTL_GAIN_LSB   = 5;
  localparam int unsigned CTL_KEEP_LSB   = 1;
  localparam int unsigned CTL_ACT_POS    = 0;

  // power-on reset values
  localparam logic        RST_MODE       = 1'h0;
  localparam logic [3:0]  RST_GAIN       = 4'hF;
  localparam logic [3:0]  RST_KEEP       = 4'h0;
  localparam logic        RST_ACT        = 1'h0;
  localparam logic [7:0]  RST_CODE       = 8'h00;
  localparam logic [3:0]  RST_BITCNT     = 4'h0;

  typedef struct packed {
    logic       single_buf;
    logic [3:0] gain;
    logic [3:0] keep_on;
    logic       soft_act;
  } qdc_ctrl_s;

  typedef enum logic [2:0] {
    QDC_IDLE  = 3'b001,
    QDC_SHIFT = 3'b010,
    QDC_WAIT  = 3'b100
  } qdc_state_e;

endpackage : qdc_pkg
